// ### bench/ebt_timer_chk.sv
`timescale 1ns/10ps
module ebt_timer_chk
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // watched inputs
    input wire logic [2:0] clockSelectField,
    input wire ebt_pkg::ebt_mode_type waveMode,
    input wire logic [2:0] timerMaskRegister,
    input wire logic countWrite,
    input wire logic [7:0] countWriteData,
    input wire logic compareWriteA,
    input wire logic [7:0] compareWriteData,
    input wire logic flagClear,
    input wire logic [2:0] flagClearData,
    // watched outputs
    input wire logic [7:0] count_value,
    input wire logic [7:0] compare_value_a,
    input wire logic [2:0] timer_flag_register,
    input wire logic [2:0] interruptRequest
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // plain up-count at full rate with no counter write
    logic run1;
    assign run1 = clockSelectField == CS_DIV1 && waveMode == WM_NORMAL && !countWrite;
    stop_hold_a: assert property (
        (clockSelectField == CS_STOP && !countWrite) [*3] |=> $stable(count_value))
        else $error("counter moved while stopped");
    write_prio_a: assert property (
        countWrite |=> count_value == $past(countWriteData))
        else $error("counter write lost");
    count_step_a: assert property (
        run1 [*3] |=> count_value == 8'($past(count_value) + 8'h01))
        else $error("counter did not step by one");
    wrap_ovf_a: assert property (
        run1 [*3] ##0 count_value == MAX_VAL |=>
        count_value == BOTTOM_VAL && timer_flag_register[FLAG_OVF])
        else $error("wrap or overflow flag wrong");
    irq_mask_a: assert property (
        interruptRequest == (timer_flag_register & timerMaskRegister))
        else $error("interrupt request not flag and mask");
    flag_clear_a: assert property (
        flagClear && flagClearData == 3'h7 && clockSelectField == CS_STOP &&
        $past(clockSelectField) == CS_STOP |=> timer_flag_register == 3'h0)
        else $error("flags not cleared");
    cmp_flag_a: assert property (
        run1 [*3] ##0 count_value == compare_value_a ##1 run1 |=>
        timer_flag_register[FLAG_CMPA])
        else $error("compare flag a missing");
    write_block_a: assert property (
        countWrite && waveMode == WM_NORMAL && countWriteData == compare_value_a &&
        count_value != compare_value_a && $past(count_value) != compare_value_a &&
        !timer_flag_register[FLAG_CMPA] && !compareWriteA |=>
        !timer_flag_register[FLAG_CMPA] [*3])
        else $error("match not blocked after counter write");
    cmp_load_a: assert property (
        compareWriteA && waveMode == WM_NORMAL |=> compare_value_a == $past(compareWriteData))
        else $error("compare value a not loaded");
endmodule

bind ebt_timer ebt_timer_chk chk (.ref_clk, .rst_n, .clockSelectField, .waveMode,
    .timerMaskRegister, .countWrite, .countWriteData, .compareWriteA, .compareWriteData,
    .flagClear, .flagClearData, .count_value, .compare_value_a, .timer_flag_register,
    .interruptRequest);

// ### bench/tb.sv
`timescale 1ns/10ps
module tb;
    import ebt_pkg::*;
    logic ref_clk, rst_n, countWrite, compareWriteA, compareWriteB, flagClear;
    logic external_count_input, forceCompareA, forceCompareB, compare_output_a;
    logic compare_output_b, compareOverrideA, compareOverrideB;
    logic [1:0] compareModeA, compareModeB;
    logic [2:0] clockSelectField, timerMaskRegister, flagClearData, interruptAck;
    logic [2:0] timer_flag_register, interruptRequest;
    logic [7:0] countWriteData, compareWriteData, count_value, compare_value_a;
    logic [7:0] compare_value_b, compareBufferA, compareBufferB;
    ebt_mode_type waveMode;
    int comparisons = 0;
    int mismatches = 0;
    int sh[5] = '{0, 3, 6, 8, 10};

    ebt_timer dut (.ref_clk, .rst_n, .clockSelectField, .waveMode, .compareModeA,
        .compareModeB, .forceCompareA, .forceCompareB, .timerMaskRegister, .countWrite,
        .countWriteData, .compareWriteA, .compareWriteB, .compareWriteData, .flagClear,
        .flagClearData, .interruptAck, .external_count_input, .count_value,
        .compare_value_a, .compare_value_b, .compareBufferA, .compareBufferB,
        .timer_flag_register, .interruptRequest, .compare_output_a, .compare_output_b,
        .compareOverrideA, .compareOverrideB);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wrCnt(input logic [7:0] d);
        countWrite = 1'b1;
        countWriteData = d;
        cyc(1);
        countWrite = 1'b0;
    endtask

    task automatic wrCmp(input logic b, input logic [7:0] d);
        if (b) begin
            compareWriteB = 1'b1;
        end else begin
            compareWriteA = 1'b1;
        end
        compareWriteData = d;
        cyc(1);
        if (b) begin
            compareWriteB = 1'b0;
        end else begin
            compareWriteA = 1'b0;
        end
    endtask

    // bounded wait, a miss shows as a mismatch
    task automatic waitCnt(input logic [7:0] v);
        for (int i = 0; i < 3000 && count_value !== v; i++) cyc(1);
        chk(count_value, v);
    endtask

    task automatic flags(input logic [2:0] v);
        chk({5'h0, timer_flag_register}, {5'h0, v});
    endtask

    task automatic results;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        cyc(40000);
        mismatches++;
        results();
    end

    initial begin
        logic [7:0] mx;
        rst_n = 1'b0;
        {countWrite, compareWriteA, compareWriteB, flagClear, external_count_input} = '0;
        {forceCompareA, forceCompareB, compareModeA, compareModeB} = '0;
        {clockSelectField, timerMaskRegister, flagClearData, interruptAck} = '0;
        {countWriteData, compareWriteData} = '0;
        waveMode = WM_NORMAL;
        cyc(6);
        rst_n = 1'b1;
        chk(count_value, RESET_VAL);
        flags(3'h0);
        wrCnt(8'h5a);
        cyc(5);
        chk(count_value, 8'h5a);
        // compares parked away from the wrap so only overflow fires
        wrCmp(1'b0, 8'h40);
        wrCmp(1'b1, 8'h80);
        chk(compare_value_b, 8'h80);
        chk(compareBufferB, 8'h80);
        timerMaskRegister = 3'h1;
        wrCnt(8'hfd);
        clockSelectField = CS_DIV1;
        waitCnt(8'h00);
        flags(3'h1);
        clockSelectField = CS_STOP;
        chk({7'h0, interruptRequest[FLAG_OVF]}, 8'h01);
        timerMaskRegister = 3'h6;
        cyc(1);
        chk({5'h0, interruptRequest}, 8'h00);
        interruptAck = 3'h1;
        cyc(1);
        interruptAck = 3'h0;
        flags(3'h0);
        wrCnt(8'h3c);
        clockSelectField = CS_DIV1;
        waitCnt(8'h44);
        clockSelectField = CS_STOP;
        flags(3'h2);
        chk({5'h0, interruptRequest}, 8'h02);
        flagClear = 1'b1;
        flagClearData = 3'h7;
        cyc(1);
        flagClear = 1'b0;
        flags(3'h0);
        // written value equals compare a, so the match must be swallowed
        wrCnt(8'h40);
        clockSelectField = CS_DIV1;
        cyc(4);
        clockSelectField = CS_STOP;
        flags(3'h0);
        compareModeA = COM_TOGGLE;
        compareModeB = COM_SET;
        cyc(1);
        chk({7'h0, compareOverrideA}, 8'h01);
        chk({7'h0, compareOverrideB}, 8'h01);
        forceCompareA = 1'b1;
        forceCompareB = 1'b1;
        cyc(1);
        forceCompareA = 1'b0;
        forceCompareB = 1'b0;
        cyc(1);
        chk({7'h0, compare_output_a}, 8'h01);
        chk({7'h0, compare_output_b}, 8'h01);
        flags(3'h0);
        wrCnt(8'h3e);
        clockSelectField = CS_DIV1;
        waitCnt(8'h44);
        clockSelectField = CS_STOP;
        chk({7'h0, compare_output_a}, 8'h00);
        compareModeB = COM_CLEAR;
        forceCompareB = 1'b1;
        cyc(1);
        forceCompareB = 1'b0;
        cyc(1);
        chk({7'h0, compare_output_b}, 8'h00);
        waveMode = WM_CTC;
        wrCmp(1'b0, 8'h05);
        wrCnt(8'h00);
        clockSelectField = CS_DIV1;
        mx = 8'h00;
        repeat (20) begin
            cyc(1);
            if (count_value > mx) mx = count_value;
        end
        chk(mx, 8'h05);
        waveMode = WM_PC_MAX;
        wrCnt(8'hfb);
        waitCnt(8'hff);
        cyc(1);
        chk(count_value, 8'hfe);
        wrCmp(1'b0, 8'h20);
        chk(compare_value_a, 8'h05);
        chk(compareBufferA, 8'h20);
        waitCnt(8'hff);
        cyc(1);
        chk(compare_value_a, 8'h20);
        clockSelectField = CS_STOP;
        waveMode = WM_NORMAL;
        // a tick of latency either way is tolerated on all five rates, CS_DIV1 through CS_DIV1024
        for (int k = 0; k < 5; k++) begin
            wrCnt(8'h00);
            clockSelectField = CS_DIV1 + 3'(k);
            cyc(4 << sh[k]);
            clockSelectField = CS_STOP;
            cyc(3);
            chk({7'h0, count_value inside {[8'h03:8'h05]}}, 8'h01);
        end
        for (int k = 0; k < 2; k++) begin
            wrCnt(8'h00);
            clockSelectField = CS_EXT_FALL + 3'(k);
            repeat (5) begin
                external_count_input = 1'b1;
                cyc(4);
                external_count_input = 1'b0;
                cyc(4);
            end
            clockSelectField = CS_STOP;
            chk(count_value, 8'h05);
        end
        results();
    end
endmodule

// ### hdl/ebt_pkg.sv
package ebt_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL = 8'hff;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam int PRE_W = 10;
    // clock select field codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03f;
    localparam logic [9:0] DIV256_MASK = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;
    // flag and mask bit positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    // waveform modes
    typedef enum logic [2:0] {
        WM_NORMAL = 3'h0,
        WM_PC_MAX = 3'h1,
        WM_CTC = 3'h2,
        WM_FAST_MAX = 3'h3,
        WM_PC_TOPA = 3'h5,
        WM_FAST_TOPA = 3'h7
    } ebt_mode_type;
    // compare output actions
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
endpackage

// ### hdl/ebt_tick_select.sv
`timescale 1ns/10ps
module ebt_tick_select
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic refClk,
    input wire logic rst_n,
    // control
    input wire logic [2:0] clockSelectField,
    input wire logic externalCountInput,
    // tick out
    output logic timerTick
);
    import ebt_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] prescale;
        logic extSync;
        logic extPrev;
    } ebt_tick_state_type;

    ebt_tick_state_type state;
    ebt_tick_state_type next_state;

    always_comb begin
        next_state = state;
        // prescaler runs free only while a source is picked, saving power when stopped
        if (clockSelectField == CS_STOP) begin
            next_state.prescale = '0;
        end else begin
            next_state.prescale = state.prescale + 1'b1;
        end
        next_state.extSync = externalCountInput;
        next_state.extPrev = state.extSync;
    end

    // source and edge choice no source means no tick
    always_comb begin
        timerTick = 1'b0;
        case (clockSelectField)
            CS_DIV1: timerTick = 1'b1;
            CS_DIV8: timerTick = ((state.prescale & DIV8_MASK) == DIV8_MASK);
            CS_DIV64: timerTick = ((state.prescale & DIV64_MASK) == DIV64_MASK);
            CS_DIV256: timerTick = ((state.prescale & DIV256_MASK) == DIV256_MASK);
            CS_DIV1024: timerTick = ((state.prescale & DIV1024_MASK) == DIV1024_MASK);
            CS_EXT_FALL: timerTick = state.extPrev & ~state.extSync;
            CS_EXT_RISE: timerTick = ~state.extPrev & state.extSync;
            default: timerTick = 1'b0;
        endcase
    end

    always_ff @(posedge refClk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ### hdl/ebt_timer.sv
`timescale 1ns/10ps
// Function
// - counter and both compare values are 8-bit registers
// - every timer interrupt request shows as a bit in the flag register
// - each interrupt has its own enable bit in the mask register
// - tick comes from the prescaled clock or the external count input
// - clock select picks both source and active edge
// - no source selected means no counting
// - compare values are checked against the counter every cycle
// - a match sets that unit's compare flag, which can request interrupt
// - compare results drive PWM or frequency waves on both outputs
// - bottom is a counter value of 0x00
// - max is a counter value of 0xFF
// - top is 0xFF or compare value A, by mode
// - three interrupt sources: overflow, compare A, compare B
// - both compare values are double buffered in pwm modes; other modes write them directly
// - clear-on-match mode gives automatic reload
// - phase-correct glitch-free PWM with variable period
// - clock select zero stops timer; counter stays readable and writable
// - a counter write beats any clear or count in the same cycle
// - compare flag sets on the tick after the match is seen
// - a counter write blocks matches on the next tick, even when stopped
module ebt_timer
    import ebt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // configuration
    input wire logic [2:0] clockSelectField,
    input wire ebt_pkg::ebt_mode_type waveMode,
    input wire logic [1:0] compareModeA,
    input wire logic [1:0] compareModeB,
    input wire logic forceCompareA,
    input wire logic forceCompareB,
    input wire logic [2:0] timerMaskRegister,
    // counter access
    input wire logic countWrite,
    input wire logic [7:0] countWriteData,
    // compare value access
    input wire logic compareWriteA,
    input wire logic compareWriteB,
    input wire logic [7:0] compareWriteData,
    // flag clear, write one to clear
    input wire logic flagClear,
    input wire logic [2:0] flagClearData,
    // interrupt service acknowledges
    input wire logic [2:0] interruptAck,
    // external count pin
    input wire logic external_count_input,
    // status
    output logic [7:0] count_value,
    output logic [7:0] compare_value_a,
    output logic [7:0] compare_value_b,
    output logic [7:0] compareBufferA,
    output logic [7:0] compareBufferB,
    output logic [2:0] timer_flag_register,
    output logic [2:0] interruptRequest,
    output logic compare_output_a,
    output logic compare_output_b,
    output logic compareOverrideA,
    output logic compareOverrideB
);
    import ebt_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] cmpA;
        logic [CNT_W-1:0] cmpB;
        logic [CNT_W-1:0] bufA;
        logic [CNT_W-1:0] bufB;
        logic [2:0] flags;
        logic countDown;
        logic blockNext;
        logic matchA;
        logic matchB;
        logic outA;
        logic outB;
    } ebt_state_type;

    ebt_state_type state;
    ebt_state_type next_state;
    logic timerTick;
    logic isPwm;
    logic isPhase;
    logic isFast;
    logic topIsA;
    logic [CNT_W-1:0] topVal;
    logic atTop;
    logic atBottom;
    logic rawMatchA;
    logic rawMatchB;
    logic [2:0] setFlags;

    ebt_tick_select #(
    ) tickSel (
        .refClk(ref_clk),
        .rst_n(rst_n),
        .clockSelectField(clockSelectField),
        .externalCountInput(external_count_input),
        .timerTick(timerTick)
    );

    function automatic logic applyCom(input logic [1:0] com, input logic cur, input logic up);
        logic res;
        res = cur;
        case (com)
            COM_TOGGLE: res = ~cur;
            COM_CLEAR: res = ~up;
            COM_SET: res = up;
            default: res = cur;
        endcase
        return res;
    endfunction

    always_comb begin
        isPhase = (waveMode == WM_PC_MAX) || (waveMode == WM_PC_TOPA);
        isFast = (waveMode == WM_FAST_MAX) || (waveMode == WM_FAST_TOPA);
        isPwm = isPhase || isFast;
        topIsA = (waveMode == WM_CTC) || (waveMode == WM_PC_TOPA) || (waveMode == WM_FAST_TOPA);
        topVal = topIsA ? state.cmpA : MAX_VAL;
        atTop = (state.count == topVal);
        atBottom = (state.count == BOTTOM_VAL);
        rawMatchA = (state.count == state.cmpA);
        rawMatchB = (state.count == state.cmpB);
    end

    always_comb begin
        next_state = state;
        setFlags = 3'h0;
        if (timerTick) begin
            // a match seen last cycle flags on this tick unless blocked
            if (state.matchA && !state.blockNext) begin
                setFlags[FLAG_CMPA] = 1'b1;
            end
            if (state.matchB && !state.blockNext) begin
                setFlags[FLAG_CMPB] = 1'b1;
            end
            next_state.blockNext = 1'b0;
            // counting sequence per mode
            if (isPhase) begin
                if (!state.countDown && atTop) begin
                    next_state.countDown = 1'b1;
                    next_state.count = state.count - 1'b1;
                end else if (state.countDown && atBottom) begin
                    next_state.countDown = 1'b0;
                    next_state.count = state.count + 1'b1;
                    setFlags[FLAG_OVF] = 1'b1;
                end else if (state.countDown) begin
                    next_state.count = state.count - 1'b1;
                end else begin
                    next_state.count = state.count + 1'b1;
                end
            end else if ((waveMode == WM_CTC || isFast) && atTop) begin
                next_state.count = BOTTOM_VAL;
                next_state.countDown = 1'b0;
                if (isFast || state.count == MAX_VAL) begin
                    setFlags[FLAG_OVF] = 1'b1;
                end
            end else begin
                next_state.countDown = 1'b0;
                next_state.count = state.count + 1'b1;
                if (state.count == MAX_VAL) begin
                    setFlags[FLAG_OVF] = 1'b1;
                end
            end
            // buffered compare values load at top in both pwm kinds, never mid-period
            if ((isPhase && !state.countDown && atTop) || (isFast && atTop)) begin
                next_state.cmpA = state.bufA;
                next_state.cmpB = state.bufB;
            end
            // waveform outputs on a real match
            if (state.matchA && !state.blockNext) begin
                next_state.outA = applyCom(compareModeA, state.outA, ~state.countDown | isFast);
            end
            if (state.matchB && !state.blockNext) begin
                next_state.outB = applyCom(compareModeB, state.outB, ~state.countDown | isFast);
            end
            // fast pwm returns the outputs at bottom
            if (isFast && atTop) begin
                if (compareModeA[1]) next_state.outA = ~compareModeA[0];
                if (compareModeB[1]) next_state.outB = ~compareModeB[0];
            end
        end
        // force strobes only in non-pwm modes, no flag and no clear
        if (forceCompareA && !isPwm) begin
            next_state.outA = applyCom(compareModeA, state.outA, 1'b1);
        end
        if (forceCompareB && !isPwm) begin
            next_state.outB = applyCom(compareModeB, state.outB, 1'b1);
        end
        // a written count equal to a compare value must not match before the next tick
        next_state.matchA = rawMatchA && !state.blockNext;
        next_state.matchB = rawMatchB && !state.blockNext;
        // counter write wins over count or clear, and blocks next tick
        if (countWrite) begin
            next_state.count = countWriteData;
            next_state.blockNext = 1'b1;
            next_state.matchA = 1'b0;
            next_state.matchB = 1'b0;
        end
        // compare writes go to the buffer; direct when not in pwm
        if (compareWriteA) begin
            next_state.bufA = compareWriteData;
            if (!isPwm) next_state.cmpA = compareWriteData;
        end
        if (compareWriteB) begin
            next_state.bufB = compareWriteData;
            if (!isPwm) next_state.cmpB = compareWriteData;
        end
        // hardware set beats clear in the same cycle
        next_state.flags = (state.flags & ~(flagClear ? flagClearData : 3'h0) & ~interruptAck)
            | setFlags;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        count_value = state.count;
        compare_value_a = state.cmpA;
        compare_value_b = state.cmpB;
        compareBufferA = state.bufA;
        compareBufferB = state.bufB;
        timer_flag_register = state.flags;
        interruptRequest = state.flags & timerMaskRegister;
        compare_output_a = state.outA;
        compare_output_b = state.outB;
        compareOverrideA = (compareModeA != COM_OFF);
        compareOverrideB = (compareModeB != COM_OFF);
    end
endmodule
